// *** hdl/smwc_cfg.svh ***
// offsets, field positions, reset values and codes of the standby controller
`ifndef SMWC_CFG_SVH
`define SMWC_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SMWC_OFF_CTRL     5'h00
`define SMWC_OFF_STATUS   5'h04
`define SMWC_OFF_IRQCFG   5'h08
`define SMWC_OFF_OSC      5'h0C
`define SMWC_OFF_INTSTAT  5'h10
`define SMWC_OFF_INTMASK  5'h14

// ----------------------------------------------------------------------------
// standby mode request codes, control bits [1:0]
// ----------------------------------------------------------------------------
`define SMWC_MODE_NONE    2'h0
`define SMWC_MODE_IDLE    2'h1
`define SMWC_MODE_DEEP    2'h2
`define SMWC_MODE_XTAL    2'h3

// ----------------------------------------------------------------------------
// pin detection codes, three bits per pin in the irq config register
// ----------------------------------------------------------------------------
`define SMWC_DET_OFF      3'h0
`define SMWC_DET_RISE     3'h1
`define SMWC_DET_FALL     3'h2
`define SMWC_DET_BOTH     3'h3
`define SMWC_DET_HIGH     3'h4
`define SMWC_DET_LOW      3'h5
`define SMWC_DET_W        3

// allowed detection codes, one bit per code
`define SMWC_ALLOW_LVLPIN 8'h36
`define SMWC_ALLOW_EDGPIN 8'h0E

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define SMWC_STAT_OSC_LSB 4
`define SMWC_INT_WAKE_BIT 8
`define SMWC_OSC_RST      4'hF
`define SMWC_IRQCFG_RST   24'h000000
`define SMWC_INTMASK_RST  9'h000

`endif

// *** hdl/smwc_pkg.sv ***
// types shared by the standby controller files
package smwc_pkg;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_IDLE,
        ST_DEEP,
        ST_XTAL
    } smwc_state_t;

    // oscillator run enables
    typedef struct packed {
        logic pll;
        logic mainRes;
        logic intRc;
        logic xtal;
    } smwc_osc_t;

    // on-chip interrupt sources that can end a standby mode
    typedef struct packed {
        logic port0;
        logic baseTimer;
        logic usbBus;
        logic irRx;
        logic other;
    } smwc_wake_t;

endpackage

// *** hdl/smwc_irq_detect.sv ***
// edge and level detector for one external interrupt pin
`timescale 1ns/100ps
`include "smwc_cfg.svh"

module smwc_irq_detect #(
    parameter logic [7:0] ALLOWED = `SMWC_ALLOW_EDGPIN
) (
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // synchronised pin level and selected detection
    input  wire logic        pinLvl,
    input  wire logic [2:0]  mode,
    // detected event
    output logic             evt
);

    logic prev_q;
    logic prev_d;
    logic evt_q;
    logic evt_d;

    // ------------------------------------------------------------------------
    // detection
    // ------------------------------------------------------------------------
    always_comb begin
        prev_d = pinLvl;
        evt_d  = 1'b0;
        if (ALLOWED[mode]) begin
            unique case (mode)
                `SMWC_DET_RISE: evt_d = pinLvl & ~prev_q;
                `SMWC_DET_FALL: evt_d = ~pinLvl & prev_q;
                `SMWC_DET_BOTH: evt_d = pinLvl ^ prev_q;
                `SMWC_DET_HIGH: evt_d = pinLvl;
                `SMWC_DET_LOW:  evt_d = ~pinLvl;
                default:        evt_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prev_q <= 1'b0;
            evt_q  <= 1'b0;
        end else if (clkEn) begin
            prev_q <= prev_d;
            evt_q  <= evt_d;
        end
    end

    assign evt = evt_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    illegal_mode_quiet_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && !ALLOWED[mode]) |=> !evt_q)
        else $error("event raised for a detection mode the pin lacks");

    rise_detect_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && mode == `SMWC_DET_RISE && pinLvl && !prev_q) |=> evt_q)
        else $error("rising edge not detected");

endmodule

// *** hdl/smwc_standby_ctrl.sv ***
// standby mode controller with wakeup logic and avalon-mm registers
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "smwc_cfg.svh"
// Behaviour
// - idle halts core, peripherals keep running
// - idle entry leaves oscillators untouched
// - idle ends on reset pin, watchdog, interrupt
// - deep standby halts core and all peripherals
// - deep entry stops pll, main, rc, crystal
// - deep ends on reset, watchdog, pins 0,1 in level mode, pins 2,4,5, port0, usb
// - crystal standby halts all but base timer
// - crystal entry stops pll, main, rc
// - crystal oscillator keeps its entry state
// - crystal ends on deep set, timer, infrared
// - pins 0,1 edges and levels, no both-edge
// - pins 2,3 edges and both-edge, no level
// - pins 4 to 7 edges and both-edge only

module smwc_standby_ctrl
    import smwc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 clkEn,
    // avalon-mm slave
    input  wire logic [4:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    input  wire logic [3:0]           byteenable,
    output logic      [31:0]          readdata,
    output logic                      waitrequest,
    // pins
    input  wire logic                 resetPinN,
    input  wire logic [7:0]           extIrq,
    // on-chip sources
    input  wire logic                 wdtReset,
    input  wire smwc_pkg::smwc_wake_t wakeSrc,
    // control outputs
    output logic                      cpuHalt,
    output logic                      periphRun,
    output logic                      baseTimerRun,
    output smwc_pkg::smwc_osc_t       oscEn,
    output logic                      sysReset,
    output logic                      irq
);
    import smwc_pkg::*;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] wdat,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic isLevel(input logic [2:0] m);
        return (m == `SMWC_DET_HIGH) || (m == `SMWC_DET_LOW);
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [8:0] sync1_q;
    logic [8:0] sync1_d;
    logic [8:0] sync2_q;
    logic [8:0] sync2_d;

    always_comb begin
        sync1_d = {resetPinN, extIrq};
        sync2_d = sync1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q <= 9'h100;
            sync2_q <= 9'h100;
        end else if (clkEn) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ------------------------------------------------------------------------
    // pin detectors
    // ------------------------------------------------------------------------
    logic [23:0] irqCfg_q;
    logic [7:0]  pinEvt;

    for (genvar i = 0; i < 8; i++) begin : g_det
        smwc_irq_detect #(
            .ALLOWED ((i < 2) ? `SMWC_ALLOW_LVLPIN : `SMWC_ALLOW_EDGPIN)
        ) u_det (
            .ref_clk (ref_clk),
            .reset   (reset),
            .clkEn   (clkEn),
            .pinLvl  (sync2_q[i]),
            .mode    (irqCfg_q[`SMWC_DET_W*i +: `SMWC_DET_W]),
            .evt     (pinEvt[i])
        );
    end

    // ------------------------------------------------------------------------
    // wake decoding
    // ------------------------------------------------------------------------
    logic sysCause;
    logic wakeIdle;
    logic wakeDeep;
    logic wakeXtal;

    always_comb begin
        sysCause = ~sync2_q[8] | wdtReset;
        wakeIdle = (|pinEvt) | (|wakeSrc);
        wakeDeep = (pinEvt[0] & isLevel(irqCfg_q[2:0]))
                 | (pinEvt[1] & isLevel(irqCfg_q[5:3]))
                 | pinEvt[2] | pinEvt[4] | pinEvt[5]
                 | wakeSrc.port0 | wakeSrc.usbBus;
        wakeXtal = wakeDeep | wakeSrc.baseTimer | wakeSrc.irRx;
    end

    // ------------------------------------------------------------------------
    // state, registers and bus
    // ------------------------------------------------------------------------
    smwc_state_t state_q;
    smwc_state_t state_d;
    smwc_osc_t   oscCfg_q;
    smwc_osc_t   oscCfg_d;
    smwc_osc_t   osc_q;
    smwc_osc_t   osc_d;
    logic [23:0] irqCfg_d;
    logic [8:0]  intStat_q;
    logic [8:0]  intStat_d;
    logic [8:0]  intMask_q;
    logic [8:0]  intMask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wait_q;
    logic        wait_d;
    logic        halt_q;
    logic        halt_d;
    logic        prun_q;
    logic        prun_d;
    logic        btRun_q;
    logic        btRun_d;
    logic        sysRst_q;
    logic        sysRst_d;
    logic        irq_q;
    logic        irq_d;
    logic        wrTake;
    logic        wake;
    logic [1:0]  modeCode;
    logic [31:0] wv;

    always_comb begin
        state_d   = state_q;
        oscCfg_d  = oscCfg_q;
        irqCfg_d  = irqCfg_q;
        intMask_d = intMask_q;
        wake      = 1'b0;
        wv        = 32'h0000_0000;
        rdata_d   = rdata_q;
        // one wait cycle, then the request is accepted
        wait_d    = ~((read | write) & wait_q);
        wrTake    = write & ~wait_q;
        unique case (state_q)
            ST_ACTIVE: modeCode = `SMWC_MODE_NONE;
            ST_IDLE:   modeCode = `SMWC_MODE_IDLE;
            ST_DEEP:   modeCode = `SMWC_MODE_DEEP;
            ST_XTAL:   modeCode = `SMWC_MODE_XTAL;
        endcase
        if (read & wait_q) begin
            unique case (address)
                `SMWC_OFF_CTRL:    rdata_d = {30'h0, modeCode};
                `SMWC_OFF_STATUS:  rdata_d = {24'h0, osc_q, 2'h0, modeCode};
                `SMWC_OFF_IRQCFG:  rdata_d = {8'h00, irqCfg_q};
                `SMWC_OFF_OSC:     rdata_d = {28'h0, oscCfg_q};
                `SMWC_OFF_INTSTAT: rdata_d = {23'h0, intStat_q};
                `SMWC_OFF_INTMASK: rdata_d = {23'h0, intMask_q};
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
        if (wrTake) begin
            unique case (address)
                `SMWC_OFF_CTRL: begin
                    wv = mergeBytes(32'h0000_0000, writedata, byteenable);
                    if (state_q == ST_ACTIVE) begin
                        unique case (wv[1:0])
                            `SMWC_MODE_IDLE: state_d = ST_IDLE;
                            `SMWC_MODE_DEEP: state_d = ST_DEEP;
                            `SMWC_MODE_XTAL: state_d = ST_XTAL;
                            `SMWC_MODE_NONE: state_d = ST_ACTIVE;
                        endcase
                    end
                end
                `SMWC_OFF_IRQCFG: begin
                    wv = mergeBytes({8'h00, irqCfg_q}, writedata, byteenable);
                    irqCfg_d = wv[23:0];
                end
                `SMWC_OFF_OSC: begin
                    wv = mergeBytes({28'h0, oscCfg_q}, writedata, byteenable);
                    oscCfg_d = wv[3:0];
                end
                `SMWC_OFF_INTMASK: begin
                    wv = mergeBytes({23'h0, intMask_q}, writedata, byteenable);
                    intMask_d = wv[8:0];
                end
                default: begin
                    wv = 32'h0000_0000;
                end
            endcase
        end
        // wakeup by interrupt: resume execution
        unique case (state_q)
            ST_ACTIVE: wake = 1'b0;
            ST_IDLE:   wake = wakeIdle;
            ST_DEEP:   wake = wakeDeep;
            ST_XTAL:   wake = wakeXtal;
        endcase
        if (wake) begin
            state_d = ST_ACTIVE;
        end
        // sticky flags: set wins over a write-one clear
        intStat_d = intStat_q;
        if (wrTake && address == `SMWC_OFF_INTSTAT) begin
            wv = mergeBytes(32'h0000_0000, writedata, byteenable);
            intStat_d = intStat_q & ~wv[8:0];
        end
        intStat_d = intStat_d | {wake, pinEvt};
        // outputs follow the next state
        halt_d  = (state_d != ST_ACTIVE);
        prun_d  = (state_d == ST_ACTIVE) || (state_d == ST_IDLE);
        btRun_d = prun_d || (state_d == ST_XTAL);
        unique case (state_d)
            ST_DEEP: osc_d = '0;
            ST_XTAL: osc_d = '{pll: 1'b0, mainRes: 1'b0, intRc: 1'b0,
                               xtal: oscCfg_q.xtal};
            default: osc_d = oscCfg_d;
        endcase
        irq_d    = |(intStat_d & intMask_q);
        sysRst_d = sysCause;
        // reset pin or watchdog: full system reset from any mode
        if (sysCause) begin
            state_d   = ST_ACTIVE;
            oscCfg_d  = `SMWC_OSC_RST;
            irqCfg_d  = `SMWC_IRQCFG_RST;
            intMask_d = `SMWC_INTMASK_RST;
            intStat_d = 9'h000;
            halt_d    = 1'b0;
            prun_d    = 1'b1;
            btRun_d   = 1'b1;
            osc_d     = `SMWC_OSC_RST;
            irq_d     = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q   <= ST_ACTIVE;
            oscCfg_q  <= `SMWC_OSC_RST;
            osc_q     <= `SMWC_OSC_RST;
            irqCfg_q  <= `SMWC_IRQCFG_RST;
            intStat_q <= 9'h000;
            intMask_q <= `SMWC_INTMASK_RST;
            rdata_q   <= 32'h0000_0000;
            wait_q    <= 1'b1;
            halt_q    <= 1'b0;
            prun_q    <= 1'b1;
            btRun_q   <= 1'b1;
            sysRst_q  <= 1'b0;
            irq_q     <= 1'b0;
        end else if (clkEn) begin
            state_q   <= state_d;
            oscCfg_q  <= oscCfg_d;
            osc_q     <= osc_d;
            irqCfg_q  <= irqCfg_d;
            intStat_q <= intStat_d;
            intMask_q <= intMask_d;
            rdata_q   <= rdata_d;
            wait_q    <= wait_d;
            halt_q    <= halt_d;
            prun_q    <= prun_d;
            btRun_q   <= btRun_d;
            sysRst_q  <= sysRst_d;
            irq_q     <= irq_d;
        end
    end

    assign readdata     = rdata_q;
    assign waitrequest  = wait_q;
    assign cpuHalt      = halt_q;
    assign periphRun    = prun_q;
    assign baseTimerRun = btRun_q;
    assign oscEn        = osc_q;
    assign sysReset     = sysRst_q;
    assign irq          = irq_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    idle_core_halt_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_d == ST_IDLE) |=> (cpuHalt && periphRun))
        else $error("idle must halt core and keep peripherals");

    idle_osc_kept_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_d == ST_IDLE) |=> (oscEn == $past(oscCfg_d)))
        else $error("idle changed oscillators");

    idle_wake_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_q == ST_IDLE && (|wakeSrc))
        |=> (state_q == ST_ACTIVE && !cpuHalt))
        else $error("idle not ended by interrupt");

    deep_stop_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_d == ST_DEEP)
        |=> (cpuHalt && !periphRun && !baseTimerRun && oscEn == '0))
        else $error("deep standby left something running");

    deep_wake_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_q == ST_DEEP && !sysCause
         && (wakeSrc.port0 || wakeSrc.usbBus || pinEvt[2]))
        |=> state_q == ST_ACTIVE)
        else $error("deep standby not ended by wake source");

    deep_timer_ignored_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_q == ST_DEEP && !sysCause && !wakeDeep
         && !wrTake) |=> state_q == ST_DEEP)
        else $error("deep standby ended without a wake source");

    xtal_state_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_d == ST_XTAL)
        |=> (baseTimerRun && !periphRun && !oscEn.pll && !oscEn.mainRes
             && !oscEn.intRc && oscEn.xtal == $past(oscCfg_q.xtal)))
        else $error("crystal standby outputs wrong");

    xtal_wake_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && state_q == ST_XTAL && (wakeSrc.baseTimer || wakeSrc.irRx))
        |=> (!cpuHalt && state_q == ST_ACTIVE))
        else $error("crystal standby not ended by timer or infrared");

    reset_wake_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (clkEn && sysCause)
        |=> (sysReset && state_q == ST_ACTIVE && oscEn == `SMWC_OSC_RST))
        else $error("reset pin or watchdog did not reset system");

endmodule

// *** verification/smwc_wake_model.sv ***
// model of the on-chip interrupt sources that end a standby mode
`timescale 1ns/100ps

module smwc_wake_model
    import smwc_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // requests from the bench
    input  wire logic                 fire,
    input  wire smwc_pkg::smwc_wake_t srcSel,
    input  wire logic [3:0]           lat,
    // core state and source levels
    input  wire logic                 cpuHalt,
    output smwc_pkg::smwc_wake_t      wakeSrc
);
    logic [3:0] cnt;
    logic       pend;
    smwc_wake_t sel;

    // a source rises lat+1 cycles after the request is sampled, held until serviced
    always @(posedge ref_clk) begin
        if (reset) begin
            pend <= 1'b0;
            cnt <= 4'h0;
            wakeSrc <= '0;
        end else if (fire) begin
            pend <= 1'b1;
            sel <= srcSel;
            cnt <= lat;
        end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend) begin
            pend <= 1'b0;
            wakeSrc <= sel;
        end else if (!cpuHalt) begin
            wakeSrc <= '0;
        end
    end
endmodule

// *** verification/tb_smwc_standby_ctrl.sv ***
// self-checking bench of the standby controller against a mode model
`timescale 1ns/100ps
`include "smwc_cfg.svh"

module tb_smwc_standby_ctrl;
    import smwc_pkg::*;
    logic        ref_clk, reset, clkEn, read, write, resetPinN, wdtReset;
    logic        waitrequest, cpuHalt, periphRun, baseTimerRun, sysReset;
    logic        irq, fire;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable, lat;
    logic [7:0]  extIrq;
    smwc_wake_t  wakeSrc, srcSel;
    smwc_osc_t   oscEn;
    int          errors, total_checks, osc, m, i, c, e;
    logic [4:0]  noWake [1:3] = '{5'h00, 5'h0A, 5'h01};
    wire  [6:0]  outs = {cpuHalt, periphRun, baseTimerRun, oscEn};

    smwc_standby_ctrl smwc_standby_ctrl_i (
        .ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .resetPinN(resetPinN), .extIrq(extIrq), .wdtReset(wdtReset),
        .wakeSrc(wakeSrc), .cpuHalt(cpuHalt), .periphRun(periphRun),
        .baseTimerRun(baseTimerRun), .oscEn(oscEn),
        .sysReset(sysReset), .irq(irq));

    smwc_wake_model smwc_wake_model_i (
        .ref_clk(ref_clk), .reset(reset), .fire(fire), .srcSel(srcSel),
        .lat(lat), .cpuHalt(cpuHalt), .wakeSrc(wakeSrc));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // model and helpers
    // ------------------------------------------------------------------
    // {cpuHalt, periphRun, baseTimerRun, pll, mainRes, intRc, xtal}
    function automatic logic [6:0] mdl(input int md, input int os);
        case (md)
            1: mdl = {3'b111, os[3:0]};
            2: mdl = 7'h40;
            3: mdl = {6'h28, os[0]};
            default: mdl = {3'b011, os[3:0]};
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        chk(waitrequest, 1'b0);
        if (waitrequest !== 1'b0)
            results();
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic fireSrc(input logic [4:0] s);
        @(posedge ref_clk);
        srcSel <= s;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
    endtask

    task automatic waitwake();
        int n;
        n = 0;
        while (cpuHalt !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (cpuHalt !== 1'b0) begin
            errors++;
            results();
        end
        @(negedge ref_clk);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(10531));
        errors = 0;
        total_checks = 0;
        reset = 1'b1;
        clkEn = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        resetPinN = 1'b1;
        wdtReset = 1'b0;
        extIrq = 8'h00;
        fire = 1'b0;
        srcSel = '0;
        lat = 4'h0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk(outs, mdl(0, 15));
        chk({sysReset, irq}, 2'b00);
        bus(0, `SMWC_OFF_OSC, 0);
        chk(q, 32'h0000000F);
        bus(0, `SMWC_OFF_IRQCFG, 0);
        chk(q, 32'h0);
        bus(0, 5'h1C, 0);
        chk(q, 32'h0);
        $display("reset test done");

        // each standby mode: entry outputs, sources that must not wake
        for (m = 1; m <= 3; m++) begin
            osc = $urandom % 16;
            lat <= 4'($urandom % 8);
            bus(1, `SMWC_OFF_OSC, osc);
            bus(1, `SMWC_OFF_CTRL, m);
            @(negedge ref_clk);
            chk(outs, mdl(m, osc));
            e = mdl(m, osc);
            bus(0, `SMWC_OFF_STATUS, 0);
            chk(q[7:0], {e[3:0], 2'b00, 2'(m)});
            bus(1, `SMWC_OFF_CTRL, 1);
            @(negedge ref_clk);
            chk(outs, mdl(m, osc));
            if (noWake[m] != 5'h00) begin
                fireSrc(noWake[m]);
                repeat (20) @(posedge ref_clk);
                chk(cpuHalt, 1'b1);
            end
            c = $urandom % 2;
            fireSrc(m == 1 ? 5'h01 : m == 2 ? (c ? 5'h10 : 5'h04)
                    : (c ? 5'h08 : 5'h02));
            waitwake();
            chk(outs, mdl(0, osc));
            chk(sysReset, 1'b0);
            bus(0, `SMWC_OFF_INTSTAT, 0);
            chk(q[8], 1'b1);
            bus(1, `SMWC_OFF_INTSTAT, 32'h1FF);
            $display("mode %0d test done", m);
        end

        // every detection code but off on every pin, rising pin
        for (i = 0; i < 8; i++) begin
            for (c = 1; c <= 5; c++) begin
                bus(1, `SMWC_OFF_IRQCFG, c << (3 * i));
                bus(1, `SMWC_OFF_INTSTAT, 32'h1FF);
                extIrq[i] <= 1'b1;
                repeat (6) @(posedge ref_clk);
                bus(0, `SMWC_OFF_INTSTAT, 0);
                e = ((i < 2 ? c != 3 : c <= 3) && c != 2) ? 1 << i : 0;
                chk(q[8:0], e);
                bus(1, `SMWC_OFF_IRQCFG, 0);
                extIrq[i] <= 1'b0;
                repeat (6) @(posedge ref_clk);
            end
        end
        $display("pin detect test done");

        // interrupt raise, mask and clear
        bus(1, `SMWC_OFF_INTSTAT, 32'h1FF);
        bus(1, `SMWC_OFF_IRQCFG, 32'h1 << 9);
        bus(1, `SMWC_OFF_INTMASK, 32'h8);
        extIrq[3] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        extIrq[3] <= 1'b0;
        @(negedge ref_clk);
        chk(irq, 1'b1);
        bus(1, `SMWC_OFF_INTMASK, 32'h0);
        repeat (2) @(negedge ref_clk);
        chk(irq, 1'b0);
        bus(1, `SMWC_OFF_INTMASK, 32'h8);
        repeat (2) @(negedge ref_clk);
        chk(irq, 1'b1);
        bus(1, `SMWC_OFF_INTSTAT, 32'h8);
        repeat (2) @(negedge ref_clk);
        chk(irq, 1'b0);
        $display("interrupt test done");

        // pin 0 wakes deep standby only in level mode
        for (c = 1; c <= 4; c += 3) begin
            bus(1, `SMWC_OFF_IRQCFG, c);
            bus(1, `SMWC_OFF_CTRL, 2);
            extIrq[0] <= 1'b1;
            repeat (12) @(posedge ref_clk);
            chk(cpuHalt, c == 4 ? 1'b0 : 1'b1);
            fireSrc(5'h10);
            waitwake();
            @(posedge ref_clk);
            extIrq[0] <= 1'b0;
        end
        bus(1, `SMWC_OFF_IRQCFG, 0);
        $display("deep pin test done");

        // a low clock enable holds deep standby despite a wake source
        bus(1, `SMWC_OFF_CTRL, 2);
        clkEn <= 1'b0;
        fireSrc(5'h10);
        repeat (12) @(posedge ref_clk);
        chk(cpuHalt, 1'b1);
        clkEn <= 1'b1;
        waitwake();
        chk(outs, mdl(0, osc));
        $display("clock enable test done");

        // reset pin and watchdog end idle with a full reset
        for (c = 0; c < 2; c++) begin
            bus(1, `SMWC_OFF_OSC, 5);
            bus(1, `SMWC_OFF_CTRL, 1);
            if (c == 1)
                wdtReset <= 1'b1;
            else
                resetPinN <= 1'b0;
            @(posedge ref_clk);
            wdtReset <= 1'b0;
            resetPinN <= 1'b1;
            i = 0;
            while (sysReset !== 1'b1 && i < 10) begin
                @(posedge ref_clk);
                i++;
            end
            chk(sysReset, 1'b1);
            if (sysReset !== 1'b1)
                results();
            repeat (4) @(negedge ref_clk);
            chk(outs, mdl(0, 15));
            bus(0, `SMWC_OFF_OSC, 0);
            chk(q, 32'h0000000F);
        end
        $display("reset wake test done");
        results();
    end
endmodule
